// ### logic/converter_defines.vh
`ifndef CONVERTER_DEFINES_VH
`define CONVERTER_DEFINES_VH
// ========================================
// Register map
`define ADDR_STATUS_CONTROL 8'h40
`define ADDR_RESULT_HIGH    8'h41
`define ADDR_RESULT_LOW     8'h42
`define ADDR_CLOCK_SETUP    8'h43
// ========================================
// Status and control fields
`define DONE_BIT            7
`define IRQ_EN_BIT          6
`define CONTINUOUS_BIT      5
`define CHAN_MSB            4
`define CHAN_LSB            0
`define CHAN_OFF            5'h1F
`define STATUS_RESET        8'h1F
`define STATUS_WR_MASK      8'h7F
// ========================================
// Clock setup fields
`define DIV_MSB             7
`define DIV_LSB             5
`define SRC_BIT             4
`define MODE_MSB            3
`define MODE_LSB            2
`define CLOCK_SETUP_RESET   8'h04
`define SRC_BUS             1'h1
`define SETUP_WR_MASK       8'hFC
// ========================================
// Justification modes
`define MODE_TRUNC          2'h0
`define MODE_RIGHT          2'h1
`define MODE_LEFT           2'h2
`define MODE_SIGNED         2'h3
// ========================================
// Divide ratios, as terminal counts
`define DIV_CODE_1          3'h0
`define DIV_CODE_2          3'h1
`define DIV_CODE_4          3'h2
`define DIV_CODE_8          3'h3
`define TERM_1              4'h0
`define TERM_2              4'h1
`define TERM_4              4'h3
`define TERM_8              4'h7
`define TERM_16             4'hF
`endif

// ### logic/result_format.v
`timescale 1ns/1ps
`default_nettype none
`include "converter_defines.vh"
module result_format (
  input  wire [1:0] mode_i,
  input  wire [9:0] code_i,
  output reg  [7:0] high_o,
  output reg  [7:0] low_o
);
  always @* begin
    high_o = 8'h00;
    low_o  = 8'h00;
    case (mode_i)
      `MODE_TRUNC: begin
        low_o = code_i[9:2];
      end
      `MODE_RIGHT: begin
        high_o = {6'h00, code_i[9:8]};
        low_o  = code_i[7:0];
      end
      `MODE_LEFT: begin
        high_o = code_i[9:2];
        low_o  = {code_i[1:0], 6'h00};
      end
      `MODE_SIGNED: begin
        high_o = {~code_i[9], code_i[8:2]};
        low_o  = {code_i[1:0], 6'h00};
      end
      default: begin
        high_o = 8'h00;
      end
    endcase
  end
endmodule
`default_nettype wire

// ### logic/converter_clock_divider.v
`timescale 1ns/1ps
`default_nettype none
`include "converter_defines.vh"
module converter_clock_divider (
  input  wire       sys_clk_i,
  input  wire       rst_b_i,
  input  wire       load_i,
  input  wire       src_i,
  input  wire [2:0] div_i,
  input  wire       xtal_tick_i,
  output reg        tick_o
);
  reg       src;
  reg [3:0] term;
  reg [3:0] count;
  reg [3:0] next_term;
  wire      src_tick;

  always @* begin
    case (div_i)
      `DIV_CODE_1: next_term = `TERM_1;
      `DIV_CODE_2: next_term = `TERM_2;
      `DIV_CODE_4: next_term = `TERM_4;
      `DIV_CODE_8: next_term = `TERM_8;
      default:     next_term = `TERM_16;
    endcase
  end

  assign src_tick = (src == `SRC_BUS) ? 1'b1 : xtal_tick_i;

  // ========================================
  // Setting is taken only at a conversion start, so the tick train never
  // sees a short or stretched period mid-conversion
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      src    <= 1'b0;
      term   <= `TERM_1;
      count  <= 4'h0;
      tick_o <= 1'b0;
    end else if (load_i) begin
      src    <= src_i;
      term   <= next_term;
      count  <= 4'h0;
      tick_o <= 1'b0;
    end else if (src_tick) begin
      tick_o <= (count == term);
      count  <= (count == term) ? 4'h0 : count + 4'h1;
    end else begin
      tick_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### logic/converter_result_control.v
`timescale 1ns/1ps
`default_nettype none
`include "converter_defines.vh"
module converter_result_control #(
  parameter RES_W = 10
) (
  input  wire             sys_clk_i,
  input  wire             rst_b_i,
  input  wire [7:0]       addr_i,
  input  wire [7:0]       wr_data_i,
  input  wire             wr_en_i,
  input  wire             rd_en_i,
  output reg  [7:0]       rd_data_o,
  input  wire             crystal_clock_i,
  input  wire             comparator_i,
  output reg  [RES_W-1:0] trial_code_o,
  output wire [4:0]       channel_o,
  output wire             converter_on_o,
  output wire             converter_clock_tick_o,
  output wire             conversion_irq_o
);
  // Engine states: idle waits for a start, convert walks one bit per tick
  localparam ST_IDLE    = 1'b0;
  localparam ST_CONVERT = 1'b1;

  // ========================================
  // Register map
  // Status and control: done flag (read only), irq enable, continuous
  //   rounds, five-bit channel; the all-ones channel turns the engine off
  // Result high and low: read only, loaded only by a finished conversion
  // Clock setup: divide field, source bit, justification field and two
  //   pad bits that always read zero
  // Unmapped addresses read zero and ignore writes

  // ========================================
  // Software registers
  reg  [7:0]       converter_status_control;
  reg  [7:0]       converter_clock_setup;
  reg  [7:0]       result_high_byte;
  reg  [7:0]       result_low_byte;
  reg              conversion_done_flag;
  reg              irq_pending;
  reg              frozen;

  // ========================================
  // Conversion engine
  reg              state;
  reg  [RES_W-1:0] mask;
  reg  [RES_W-1:0] next_trial;
  reg              done_pulse;
  reg  [RES_W-1:0] final_code;
  reg              start;

  // ========================================
  // Crystal clock synchroniser
  reg  [2:0]       xtal_sync;
  reg              xtal_level;
  wire             xtal_tick;

  wire             wr_status;
  wire             rd_high;
  wire             rd_low;
  wire             result_read;
  wire             irq_enable;
  wire             continuous;
  wire [4:0]       channel;
  wire [1:0]       justification_field;
  wire             tick;
  wire [7:0]       fmt_high;
  wire [7:0]       fmt_low;
  wire             wr_setup;
  wire [7:0]       status_wr_value;
  wire [7:0]       setup_wr_value;
  wire [7:0]       status_rd_value;
  wire [4:0]       wr_channel;
  wire             wr_channel_on;
  wire             done_format;
  wire             result_update;

  // ========================================
  // Address decode
  assign wr_status  = wr_en_i && (addr_i == `ADDR_STATUS_CONTROL);
  assign wr_setup   = wr_en_i && (addr_i == `ADDR_CLOCK_SETUP);
  assign rd_high    = rd_en_i && (addr_i == `ADDR_RESULT_HIGH);
  assign rd_low     = rd_en_i && (addr_i == `ADDR_RESULT_LOW);
  assign result_read = rd_high || rd_low;

  // ========================================
  // Field views of the bus data; the done flag position and the setup pad
  // bits are never stored from a write
  assign status_wr_value = wr_data_i & `STATUS_WR_MASK;
  assign setup_wr_value  = wr_data_i & `SETUP_WR_MASK;
  assign status_rd_value = {conversion_done_flag,
                            converter_status_control[`IRQ_EN_BIT:`CHAN_LSB]};
  assign wr_channel      = wr_data_i[`CHAN_MSB:`CHAN_LSB];
  assign wr_channel_on   = (wr_channel != `CHAN_OFF);

  assign irq_enable = converter_status_control[`IRQ_EN_BIT];
  assign continuous = converter_status_control[`CONTINUOUS_BIT];
  assign channel    = converter_status_control[`CHAN_MSB:`CHAN_LSB];
  assign justification_field = converter_clock_setup[`MODE_MSB:`MODE_LSB];

  // ========================================
  // Outputs; the converter is powered only while a real channel is chosen
  assign channel_o        = channel;
  assign converter_on_o   = (channel != `CHAN_OFF);
  assign conversion_irq_o = irq_pending;
  assign converter_clock_tick_o = tick;

  // ========================================
  // Crystal edge detection; stage 0 feeds only stage 1
  // Stage 0 may go metastable; a level counts only once stages 1 and 2
  // agree, which costs two to three cycles on each crystal edge
  // Each crystal half period must span at least two bus clocks
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      xtal_sync  <= 3'h0;
      xtal_level <= 1'b0;
    end else begin
      xtal_sync <= {xtal_sync[1:0], crystal_clock_i};
      if (xtal_sync[1] == xtal_sync[2]) begin
        xtal_level <= xtal_sync[2];
      end
    end
  end

  // One-cycle pulse on each settled rising crystal edge
  assign xtal_tick = (xtal_sync[1] == xtal_sync[2]) && xtal_sync[2] && !xtal_level;

  // ========================================
  // Clock setup register
  // The two pad bits are dropped on write and always read zero
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      converter_clock_setup <= `CLOCK_SETUP_RESET;
    end else if (wr_setup) begin
      converter_clock_setup <= setup_wr_value;
    end
  end

  // ========================================
  // Status and control register
  // The done flag position is read only; a one written there is dropped
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      converter_status_control <= `STATUS_RESET;
    end else if (wr_status) begin
      converter_status_control <= status_wr_value;
    end
  end

  // ========================================
  // Start request: a control write, or the next round in continuous mode
  // A stop write (channel all ones) leaves the done flag as it was
  // Continuous rounds restart in the cycle the code is handed over; the start
  // reloads the divider, so the tick train begins again from a zero count
  always @* begin
    start = 1'b0;
    if (wr_status) begin
      start = wr_channel_on;
    end else if (done_pulse && continuous && (channel != `CHAN_OFF)) begin
      start = 1'b1;
    end
  end

  // Source and divide reach the divider only at a start, so a setup write
  // during a conversion applies from the next one
  converter_clock_divider u_divider (
    .sys_clk_i   (sys_clk_i),
    .rst_b_i     (rst_b_i),
    .load_i      (start),
    .src_i       (converter_clock_setup[`SRC_BIT]),
    .div_i       (converter_clock_setup[`DIV_MSB:`DIV_LSB]),
    .xtal_tick_i (xtal_tick),
    .tick_o      (tick)
  );

  // ========================================
  // Successive approximation, one bit per converter clock tick
  // The comparator is read on the tick edge, so a trial code must settle
  // through the DAC within one tick; divide 1 on the bus clock leaves it a
  // single cycle
  always @* begin
    next_trial = comparator_i ? trial_code_o : (trial_code_o & ~mask);
  end

  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state        <= ST_IDLE;
      mask         <= {RES_W{1'b0}};
      trial_code_o <= {RES_W{1'b0}};
      final_code   <= {RES_W{1'b0}};
      done_pulse   <= 1'b0;
    end else begin
      done_pulse <= 1'b0;
      if (start) begin
        // A write mid-conversion drops the partial code and begins again
        state        <= ST_CONVERT;
        mask         <= {1'b1, {(RES_W-1){1'b0}}};
        trial_code_o <= {1'b1, {(RES_W-1){1'b0}}};
      end else if (wr_status) begin
        state <= ST_IDLE;
      end else begin
        case (state)
          ST_IDLE: begin
            mask <= {RES_W{1'b0}};
          end
          ST_CONVERT: begin
            if (tick) begin
              // The last tick settles bit 0 and hands the code over
              if (mask[0]) begin
                final_code <= next_trial;
                done_pulse <= 1'b1;
                state      <= ST_IDLE;
              end else begin
                mask         <= mask >> 1;
                trial_code_o <= next_trial | (mask >> 1);
              end
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  result_format u_format (
    .mode_i (justification_field),
    .code_i (final_code),
    .high_o (fmt_high),
    .low_o  (fmt_low)
  );

  // ========================================
  // Freeze interlock between the two result bytes
  // Both bytes are held while frozen, so a high/low pair comes from one conversion
  // unless one finishes in the cycle of the high read; the price is that results finishing in between are lost
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      frozen <= 1'b0;
    end else if (justification_field == `MODE_TRUNC) begin
      // Truncation mode clears any freeze, so low updates never stall
      frozen <= 1'b0;
    end else if (rd_low) begin
      frozen <= 1'b0;
    end else if (rd_high) begin
      frozen <= 1'b1;
    end
  end

  // ========================================
  // Result bytes keep their contents through reset; software must not trust
  // them before the first completed conversion
  assign done_format   = done_pulse;
  assign result_update = done_format && !frozen;

  always @(posedge sys_clk_i) begin
    if (result_update) begin
      result_high_byte <= fmt_high;
      result_low_byte  <= fmt_low;
    end
  end
  // A result finishing while frozen is simply not stored

  // ========================================
  // Completion flag and interrupt request; a new completion beats a clear
  // With the request enabled the flag never sets and reads zero, so a
  // polling loop and an interrupt handler never both claim one completion;
  // a finished conversion that is dropped while frozen still raises them
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      conversion_done_flag <= 1'b0;
      irq_pending          <= 1'b0;
    end else begin
      if (done_pulse && !irq_enable) begin
        conversion_done_flag <= 1'b1;
      end else if (result_read || irq_enable) begin
        conversion_done_flag <= 1'b0;
      end
      if (done_pulse && irq_enable) begin
        irq_pending <= 1'b1;
      end else if (result_read || wr_status) begin
        irq_pending <= 1'b0;
      end
    end
  end

  // ========================================
  // Read port: data stand one cycle after the strobe; unmapped reads zero
  // Data drop back to zero after one cycle, so a stale byte is never
  // mistaken for the answer to a later strobe
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_data_o <= 8'h00;
    end else if (rd_en_i) begin
      case (addr_i)
        `ADDR_STATUS_CONTROL: begin
          rd_data_o <= status_rd_value;
        end
        `ADDR_RESULT_HIGH: begin
          rd_data_o <= result_high_byte;
        end
        `ADDR_RESULT_LOW: begin
          rd_data_o <= result_low_byte;
        end
        `ADDR_CLOCK_SETUP: begin
          rd_data_o <= converter_clock_setup;
        end
        default: begin
          rd_data_o <= 8'h00;
        end
      endcase
    end else begin
      rd_data_o <= 8'h00;
    end
  end
endmodule
`default_nettype wire

// ### sim/converter_result_chk.sv
`timescale 1ns/1ps
`default_nettype none
module converter_result_chk #(
  parameter RES_W = 10
) (
  input wire logic             sys_clk_i,
  input wire logic             rst_b_i,
  input wire logic [7:0]       addr_i,
  input wire logic [7:0]       wr_data_i,
  input wire logic             wr_en_i,
  input wire logic             rd_en_i,
  input wire logic [7:0]       rd_data_o,
  input wire logic             crystal_clock_i,
  input wire logic             comparator_i,
  input wire logic [RES_W-1:0] trial_code_o,
  input wire logic [4:0]       channel_o,
  input wire logic             converter_on_o,
  input wire logic             converter_clock_tick_o,
  input wire logic             conversion_irq_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  // ========================================
  // Bus sequences
  sequence start_seq;
    wr_en_i && addr_i == 8'h40 && wr_data_i[4:0] != 5'h1F;
  endsequence
  sequence res_rd_seq;
    rd_en_i && (addr_i == 8'h41 || addr_i == 8'h42);
  endsequence
  // ========================================
  // Properties
  a_idle_zero:
    assert property (!rd_en_i |=> rd_data_o == 8'h00) else $error("idle read data not zero");
  a_setup_pad:
    assert property (rd_en_i && addr_i == 8'h43 |=> rd_data_o[1:0] == 2'h0)
    else $error("clock setup pad bits not zero");
  a_chan_load:
    assert property (wr_en_i && addr_i == 8'h40 |=> channel_o == $past(wr_data_i[4:0]))
    else $error("channel not loaded by status write");
  a_sar_start:
    assert property (start_seq |=> trial_code_o == 10'h200) else $error("trial code not restarted");
  a_no_early:
    assert property (start_seq |=> !conversion_irq_o [*8]) else $error("completion too early");
  a_irq_rd_clr:
    assert property (conversion_irq_o ##0 res_rd_seq |=> !conversion_irq_o)
    else $error("irq held after result read");
  a_irq_wr_clr:
    assert property (conversion_irq_o && wr_en_i && addr_i == 8'h40 |=> !conversion_irq_o)
    else $error("irq held after status write");
  a_done_masked:
    assert property (conversion_irq_o && rd_en_i && addr_i == 8'h40 |=> !rd_data_o[7])
    else $error("done flag visible with irq enabled");
endmodule
`default_nettype wire

// ### sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        sys_clk_i = 0;
  logic        rst_b_i = 0;
  logic [7:0]  addr_i = 0;
  logic [7:0]  wr_data_i = 0;
  logic        wr_en_i = 0;
  logic        rd_en_i = 0;
  logic        crystal_clock_i = 0;
  logic [7:0]  d;
  logic [9:0]  ana = 0;
  logic [9:0]  v;
  logic [9:0]  a;
  logic [15:0] e;
  wire  [7:0]  rd_data_o;
  wire  [9:0]  trial_code_o;
  wire  [4:0]  channel_o;
  wire         converter_on_o;
  wire         converter_clock_tick_o;
  wire         conversion_irq_o;
  int          err_count = 0;
  int          total_checks = 0;
  int          gap = 0;
  int          cnt = 0;
  int          xc = 0;
  int          m;
  // Ideal comparator, so a correct SAR lands exactly on the input code
  wire         comparator_i = (ana >= trial_code_o);

  converter_result_control DUT (.sys_clk_i, .rst_b_i, .addr_i, .wr_data_i, .wr_en_i, .rd_en_i,
    .rd_data_o, .crystal_clock_i, .comparator_i, .trial_code_o, .channel_o, .converter_on_o,
    .converter_clock_tick_o, .conversion_irq_o);

  initial forever #5 sys_clk_i = ~sys_clk_i;
  // ========================================
  // Slow crystal and tick spacing monitor
  always @(posedge sys_clk_i) begin
    xc <= xc + 1;
    if (xc % 4 == 3) crystal_clock_i <= ~crystal_clock_i;
    if (converter_clock_tick_o) begin
      gap <= cnt + 1;
      cnt <= 0;
    end else cnt <= cnt + 1;
  end
  // ========================================
  // Reference model and bus tasks
  function automatic logic [15:0] fmt(input logic [1:0] md, input logic [9:0] r);
    case (md)
      2'h0: return {8'h00, r[9:2]};
      2'h1: return {6'h00, r};
      2'h2: return {r, 6'h00};
      default: return {~r[9], r[8:0], 6'h00};
    endcase
  endfunction
  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input string n, input logic [15:0] ex, input logic [15:0] got);
    total_checks++;
    if (got !== ex) begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", n, ex, got);
    end
  endtask
  task wr(input logic [7:0] ad, input logic [7:0] wd);
    @(posedge sys_clk_i);
    wr_en_i <= 1;
    addr_i <= ad;
    wr_data_i <= wd;
    @(posedge sys_clk_i);
    wr_en_i <= 0;
  endtask
  task rd(input logic [7:0] ad);
    @(posedge sys_clk_i);
    rd_en_i <= 1;
    addr_i <= ad;
    @(posedge sys_clk_i);
    rd_en_i <= 0;
    #1 d = rd_data_o;
  endtask
  task pair;
    rd(8'h41);
    e[15:8] = d;
    rd(8'h42);
    e[7:0] = d;
  endtask
  task start(input logic [9:0] r, input bit irq);
    ana <= r;
    wr(8'h40, {1'b0, irq, 6'h00});
  endtask
  // Polls the done flag, or the irq pin when the flag is masked
  task wt(input bit irq);
    for (m = 0; m < 500; m++) begin
      if (irq) begin
        @(posedge sys_clk_i);
        #1;
      end else rd(8'h40);
      if (irq ? conversion_irq_o === 1'b1 : d[7] === 1'b1) break;
    end
    if (m == 500) begin
      err_count++;
      $display("CHECK FAILED wait exp done got none");
      give_verdict;
    end
  endtask
  task conv(input logic [7:0] s, input logic [9:0] r);
    wr(8'h43, s);
    start(r, 0);
    wt(0);
  endtask
  // ========================================
  // Main sequence
  initial begin
    void'($urandom(78310));
    repeat (4) @(posedge sys_clk_i);
    rst_b_i <= 1;
    rd(8'h43); chk("setup_reset", 16'h0004, {8'h00, d});
    rd(8'h40); chk("status_reset", 16'h001F, {8'h00, d});
    chk("on_reset", 16'h0000, {15'h0000, converter_on_o});
    for (int k = 0; k < 8; k++) begin
      v = (k == 0) ? 10'h000 : (k == 7) ? 10'h3FF : 10'($urandom);
      conv({k[2:0], 1'b1, k[1:0], 2'h0}, v);
      pair; chk("result", fmt(k[1:0], v), e);
      chk("tick_gap", (k < 4) ? (16'h0001 << k) : 16'h0010, gap[15:0]);
    end
    $display("test modes done");
    v = 10'($urandom);
    conv(8'h04, v);
    chk("xtal_gap", 16'h0008, gap[15:0]);
    pair; chk("xtal_result", fmt(2'h1, v), e);
    rd(8'h40); chk("done_cleared", 16'h0000, {15'h0000, d[7]});
    $display("test crystal done");
    a = 10'($urandom);
    v = ~a;
    wr(8'h43, 8'h14);
    start(a, 0);
    repeat (3) @(posedge sys_clk_i);
    start(v, 0);
    wt(0);
    pair; chk("abort_result", fmt(2'h1, v), e);
    $display("test abort done");
    a = 10'($urandom);
    conv(8'h14, a);
    rd(8'h41);
    e[15:8] = d;
    conv(8'h14, ~a);
    rd(8'h42);
    e[7:0] = d;
    chk("frozen_pair", fmt(2'h1, a), e);
    wr(8'h41, 8'hFF);
    rd(8'h41); chk("high_no_write", fmt(2'h1, a) >> 8, {8'h00, d});
    rd(8'h42);
    $display("test freeze done");
    a = 10'($urandom);
    conv(8'h10, a);
    rd(8'h41);
    conv(8'h10, ~a);
    rd(8'h42); chk("trunc_low", {8'h00, ~a[9:2]}, {8'h00, d});
    $display("test truncation done");
    a = 10'($urandom);
    wr(8'h43, 8'h14);
    ana <= a;
    wr(8'h40, 8'h20);
    #1 chk("conv_on", 16'h0001, {15'h0000, converter_on_o});
    repeat (2) begin
      wt(0);
      pair;
    end
    chk("cont_result", fmt(2'h1, a), e);
    wr(8'h40, 8'h1F);
    $display("test continuous done");
    wr(8'h43, 8'h14);
    start(a, 1);
    wt(1);
    rd(8'h40); chk("done_masked", 16'h0000, {15'h0000, d[7]});
    rd(8'h42); chk("irq_read_clear", 16'h0000, {15'h0000, conversion_irq_o});
    start(a, 1);
    wt(1);
    wr(8'h40, 8'h1F);
    #1 chk("irq_write_clear", 16'h0000, {15'h0000, conversion_irq_o});
    chk("conv_off", 16'h0000, {15'h0000, converter_on_o});
    $display("test irq done");
    give_verdict;
  end
endmodule

bind converter_result_control converter_result_chk #(.RES_W(RES_W)) chk_i (.sys_clk_i,
  .rst_b_i, .addr_i, .wr_data_i, .wr_en_i, .rd_en_i, .rd_data_o, .crystal_clock_i,
  .comparator_i, .trial_code_o, .channel_o, .converter_on_o, .converter_clock_tick_o,
  .conversion_irq_o);
`default_nettype wire
